// ===== common/aogt_pkg.sv
// ---------------------------------------------------------------------------
// constants for the offset and fine gain trim register bank
// ---------------------------------------------------------------------------
package aogt_pkg;

    // ------------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------------
    localparam int ADDR_W = 12;  // register address width
    localparam int DATA_W = 16;  // register data width

    // ------------------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------------------
    localparam logic [11:0] ADDR_OFFSET_TRIM_CORE2_INPUT_B = 12'h336;
    localparam logic [11:0] ADDR_OFFSET_TRIM_CORE3_INPUT_C = 12'h338;
    localparam logic [11:0] ADDR_OFFSET_TRIM_CORE3_INPUT_D = 12'h33a;
    localparam logic [11:0] ADDR_OFFSET_TRIM_CORE4 = 12'h33c;
    localparam logic [11:0] ADDR_OFFSET_TRIM_CORE5 = 12'h33e;
    localparam logic [11:0] ADDR_FINE_GAIN_CORE0 = 12'h360;
    localparam logic [11:0] ADDR_FINE_GAIN_CORE1 = 12'h361;
    localparam logic [11:0] ADDR_FINE_GAIN_CORE2_INPUT_A = 12'h362;
    localparam logic [11:0] ADDR_TRIM_STATUS = 12'h3f0;   // load status
    localparam logic [11:0] ADDR_TRIM_CONTROL = 12'h3f2;  // reload command

    // ------------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------------
    localparam int OFS_FIELD_W = 12;  // offset field bits 11:0
    localparam int GAIN_FIELD_W = 5;  // gain field bits 4:0
    localparam int NUM_OFS = 5;       // offset trim registers held here
    localparam int NUM_GAIN = 3;      // gain trim registers held here
    localparam int NUM_FUSE = 8;      // fuse words, offsets first then gains
    localparam int STAT_DONE_BIT = 0;      // fuse load has completed
    localparam int STAT_BUSY_BIT = 1;      // fuse load in progress
    localparam int STAT_CAL_BIT = 2;       // offset calibration running
    localparam int CTRL_RELOAD_BIT = 0;    // write 1 to reload from fuses

    // ------------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------------
    localparam logic [11:0] OFS_RESET = 12'h000;
    localparam logic [4:0] GAIN_RESET = 5'h00;
    localparam logic [15:0] RDATA_RESET = 16'h0000;

    // ------------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [11:0] addr;   // register address
        logic [15:0] wdata;  // write data
        logic wr;            // write strobe
        logic rd;            // read strobe
    } aogt_bus_req_type;

endpackage : aogt_pkg

// ===== verilog/aogt_trim_regs.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - core2 input b uses its offset field
// - core3 keeps separate offsets for c, d
// - cores 4 and 5 use own offsets
// - offset registers load from fuses after reset
// - cores 0,1 gain in bits 4:0
// - core2 gain only on input a
// - gain registers load from fuses after reset
// - offset fields are unsigned values
module aogt_trim_regs #(
    parameter int OFS_W = aogt_pkg::OFS_FIELD_W,   // offset field width
    parameter int GAIN_W = aogt_pkg::GAIN_FIELD_W  // gain field width
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire aogt_pkg::aogt_bus_req_type bus_req,
    output logic [15:0] bus_rdata,
    // fuse memory read port
    output logic fuse_rd_en,
    output logic [2:0] fuse_rd_index,
    input wire logic [15:0] fuse_rd_data,
    input wire logic fuse_rd_valid,
    // converter core input selection and calibration state
    input wire logic core2_sel_input_b,
    input wire logic core3_sel_input_d,
    input wire logic offset_cal_busy,
    // trim values toward the converter cores
    output logic [OFS_W-1:0] core2_offset,
    output logic core2_offset_valid,
    output logic [OFS_W-1:0] core3_offset,
    output logic [OFS_W-1:0] core4_offset,
    output logic [OFS_W-1:0] core5_offset,
    output logic [GAIN_W-1:0] core0_gain,
    output logic [GAIN_W-1:0] core1_gain,
    output logic [GAIN_W-1:0] core2_gain,
    output logic core2_gain_valid,
    // load status
    output logic fuse_load_done
);

    // ------------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------------
    // fields must fit the 16-bit and 8-bit register words
    if (OFS_W < 1 || OFS_W > 12) begin : g_bad_ofs
        $error("offset field width must be 1 to 12");
    end
    if (GAIN_W < 1 || GAIN_W > 5) begin : g_bad_gain
        $error("gain field width must be 1 to 5");
    end

    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    // index 0 core2 b, 1 core3 c, 2 core3 d, 3 core4, 4 core5
    logic [OFS_W-1:0] ofs_r [0:aogt_pkg::NUM_OFS-1];
    // index 0 core0, 1 core1, 2 core2 a
    logic [GAIN_W-1:0] gain_r [0:aogt_pkg::NUM_GAIN-1];

    // fuse loader state
    typedef enum logic [1:0] {
        LD_REQ,
        LD_WAIT,
        LD_DONE
    } aogt_load_state_type;

    aogt_load_state_type ld_state_r;  // loader state
    logic [2:0] ld_index_r;           // fuse word being fetched
    logic fuse_rd_en_r;               // one-cycle fuse read request
    logic load_done_r;                // all fuse words stored
    logic [15:0] rdata_r;             // read data, one cycle after strobe

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    logic ofs_hit;                              // address names an offset
    logic [2:0] ofs_idx;                        // which offset
    logic gain_hit;                             // address names a gain
    logic [1:0] gain_idx;                       // which gain
    logic sw_wr;                                // write allowed this cycle
    logic reload_cmd;                           // reload request written
    logic fuse_store;                           // fuse word arriving now
    logic [OFS_W-1:0] fuse_ofs_val;             // fuse word as offset
    logic [GAIN_W-1:0] fuse_gain_val;           // fuse word as gain

    // decode the offset and gain windows
    always_comb begin
        ofs_hit = 1'b1;
        ofs_idx = 3'h0;
        gain_hit = 1'b1;
        gain_idx = 2'h0;
        unique case (bus_req.addr)
            aogt_pkg::ADDR_OFFSET_TRIM_CORE2_INPUT_B: ofs_idx = 3'h0;
            aogt_pkg::ADDR_OFFSET_TRIM_CORE3_INPUT_C: ofs_idx = 3'h1;
            aogt_pkg::ADDR_OFFSET_TRIM_CORE3_INPUT_D: ofs_idx = 3'h2;
            aogt_pkg::ADDR_OFFSET_TRIM_CORE4: ofs_idx = 3'h3;
            aogt_pkg::ADDR_OFFSET_TRIM_CORE5: ofs_idx = 3'h4;
            default: ofs_hit = 1'b0;
        endcase
        unique case (bus_req.addr)
            aogt_pkg::ADDR_FINE_GAIN_CORE0: gain_idx = 2'h0;
            aogt_pkg::ADDR_FINE_GAIN_CORE1: gain_idx = 2'h1;
            aogt_pkg::ADDR_FINE_GAIN_CORE2_INPUT_A: gain_idx = 2'h2;
            default: gain_hit = 1'b0;
        endcase
    end

    // software writes are held off while fuses are loading, so a half
    // loaded bank is never mixed with software values
    assign sw_wr = bus_req.wr && (ld_state_r == LD_DONE);
    // reload only from the idle loader; a second request mid-load is moot
    assign reload_cmd = sw_wr && (bus_req.addr == aogt_pkg::ADDR_TRIM_CONTROL)
                        && bus_req.wdata[aogt_pkg::CTRL_RELOAD_BIT];
    assign fuse_store = (ld_state_r == LD_WAIT) && fuse_rd_valid;
    // fuse words carry the field in their low bits, reserved bits dropped
    assign fuse_ofs_val = fuse_rd_data[OFS_W-1:0];
    assign fuse_gain_val = fuse_rd_data[GAIN_W-1:0];

    // ------------------------------------------------------------------------
    // fuse loader
    // ------------------------------------------------------------------------
    // walks every fuse word once after reset and again on each reload
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ld_state_r <= LD_REQ;  // start fetching at the first edge
            ld_index_r <= 3'h0;
            fuse_rd_en_r <= 1'b0;
            load_done_r <= 1'b0;
        end else begin
            fuse_rd_en_r <= 1'b0;
            unique case (ld_state_r)
                // issue one read for the current word
                LD_REQ: begin
                    fuse_rd_en_r <= 1'b1;
                    ld_state_r <= LD_WAIT;
                end
                // hold until the fuse memory answers, then step on
                LD_WAIT: begin
                    if (fuse_rd_valid) begin
                        if (ld_index_r == 3'(aogt_pkg::NUM_FUSE - 1)) begin
                            ld_state_r <= LD_DONE;
                            ld_index_r <= 3'h0;
                            load_done_r <= 1'b1;
                        end else begin
                            ld_index_r <= ld_index_r + 3'h1;
                            ld_state_r <= LD_REQ;
                        end
                    end
                end
                // idle until software asks for a reload
                LD_DONE: begin
                    if (reload_cmd) begin
                        ld_state_r <= LD_REQ;
                        load_done_r <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // offset trim registers
    // ------------------------------------------------------------------------
    // fuse value wins while loading; software writes land only afterwards.
    // writes during offset calibration are dropped so the engine's own
    // result is not overwritten halfway
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < aogt_pkg::NUM_OFS; i++) begin
                ofs_r[i] <= aogt_pkg::OFS_RESET[OFS_W-1:0];
            end
        end else if (fuse_store && (ld_index_r < 3'(aogt_pkg::NUM_OFS))) begin
            ofs_r[ld_index_r] <= fuse_ofs_val;
        end else if (sw_wr && ofs_hit && !offset_cal_busy) begin
            // only bits 11:0 are kept; reserved bits are not stored
            ofs_r[ofs_idx] <= bus_req.wdata[OFS_W-1:0];
        end
    end

    // ------------------------------------------------------------------------
    // fine gain trim registers
    // ------------------------------------------------------------------------
    // gain fuse words follow the five offset words
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < aogt_pkg::NUM_GAIN; i++) begin
                gain_r[i] <= aogt_pkg::GAIN_RESET[GAIN_W-1:0];
            end
        end else if (fuse_store && (ld_index_r >= 3'(aogt_pkg::NUM_OFS))) begin
            gain_r[2'(ld_index_r - 3'(aogt_pkg::NUM_OFS))] <= fuse_gain_val;
        end else if (sw_wr && gain_hit) begin
            // bits 7:5 are unused and dropped
            gain_r[gain_idx] <= bus_req.wdata[GAIN_W-1:0];
        end
    end

    // ------------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------------
    // data appears the cycle after the strobe and is zero otherwise;
    // unmapped addresses and reserved bits read as zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_r <= aogt_pkg::RDATA_RESET;
        end else begin
            rdata_r <= aogt_pkg::RDATA_RESET;
            if (bus_req.rd) begin
                if (ofs_hit) begin
                    // reads during calibration give zero, not a moving value
                    if (!offset_cal_busy) begin
                        rdata_r <= 16'(ofs_r[ofs_idx]);
                    end
                end else if (gain_hit) begin
                    rdata_r <= 16'(gain_r[gain_idx]);
                end else if (bus_req.addr == aogt_pkg::ADDR_TRIM_STATUS) begin
                    rdata_r[aogt_pkg::STAT_DONE_BIT] <= load_done_r;
                    rdata_r[aogt_pkg::STAT_BUSY_BIT] <= (ld_state_r != LD_DONE);
                    rdata_r[aogt_pkg::STAT_CAL_BIT] <= offset_cal_busy;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // trim values toward the converter cores
    // ------------------------------------------------------------------------
    logic [OFS_W-1:0] core2_offset_r;   // core2 offset in use
    logic core2_offset_valid_r;         // core2 offset applies now
    logic [OFS_W-1:0] core3_offset_r;   // core3 offset in use
    logic [OFS_W-1:0] core4_offset_r;   // core4 offset
    logic [OFS_W-1:0] core5_offset_r;   // core5 offset
    logic [GAIN_W-1:0] core0_gain_r;    // core0 gain
    logic [GAIN_W-1:0] core1_gain_r;    // core1 gain
    logic [GAIN_W-1:0] core2_gain_r;    // core2 gain in use
    logic core2_gain_valid_r;           // core2 gain applies now

    // offsets pass unsigned, zero extended by the cores, no sign bit
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            core2_offset_r <= aogt_pkg::OFS_RESET[OFS_W-1:0];
            core2_offset_valid_r <= 1'b0;
            core3_offset_r <= aogt_pkg::OFS_RESET[OFS_W-1:0];
            core4_offset_r <= aogt_pkg::OFS_RESET[OFS_W-1:0];
            core5_offset_r <= aogt_pkg::OFS_RESET[OFS_W-1:0];
        end else begin
            // the input a value of core2 lives outside this bank, so the
            // offset is offered only while input b is sampled
            if (core2_sel_input_b) begin
                core2_offset_r <= ofs_r[0];
            end else begin
                core2_offset_r <= aogt_pkg::OFS_RESET[OFS_W-1:0];
            end
            core2_offset_valid_r <= core2_sel_input_b;
            // two independent values, picked by the input in use
            if (core3_sel_input_d) begin
                core3_offset_r <= ofs_r[2];
            end else begin
                core3_offset_r <= ofs_r[1];
            end
            core4_offset_r <= ofs_r[3];
            core5_offset_r <= ofs_r[4];
        end
    end

    // gains follow the registers, core2 only on its first input
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            core0_gain_r <= aogt_pkg::GAIN_RESET[GAIN_W-1:0];
            core1_gain_r <= aogt_pkg::GAIN_RESET[GAIN_W-1:0];
            core2_gain_r <= aogt_pkg::GAIN_RESET[GAIN_W-1:0];
            core2_gain_valid_r <= 1'b0;
        end else begin
            core0_gain_r <= gain_r[0];
            core1_gain_r <= gain_r[1];
            if (!core2_sel_input_b) begin
                core2_gain_r <= gain_r[2];
            end else begin
                core2_gain_r <= aogt_pkg::GAIN_RESET[GAIN_W-1:0];
            end
            core2_gain_valid_r <= !core2_sel_input_b;
        end
    end

    // ------------------------------------------------------------------------
    // output wiring
    // ------------------------------------------------------------------------
    assign bus_rdata = rdata_r;
    assign fuse_rd_en = fuse_rd_en_r;
    assign fuse_rd_index = ld_index_r;
    assign fuse_load_done = load_done_r;
    assign core2_offset = core2_offset_r;
    assign core2_offset_valid = core2_offset_valid_r;
    assign core3_offset = core3_offset_r;
    assign core4_offset = core4_offset_r;
    assign core5_offset = core5_offset_r;
    assign core0_gain = core0_gain_r;
    assign core1_gain = core1_gain_r;
    assign core2_gain = core2_gain_r;
    assign core2_gain_valid = core2_gain_valid_r;

endmodule // aogt_trim_regs

`default_nettype wire

// ===== sim/aogt_trim_regs_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// port checker for the trim register bank
// ---------------------------------------------------------------------------
module aogt_trim_regs_checker #(
    parameter int OFS_W = aogt_pkg::OFS_FIELD_W,  // offset field width
    parameter int GAIN_W = aogt_pkg::GAIN_FIELD_W  // gain field width
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire aogt_pkg::aogt_bus_req_type bus_req,
    input wire logic [15:0] bus_rdata,
    // fuse port
    input wire logic fuse_rd_en,
    input wire logic [2:0] fuse_rd_index,
    input wire logic [15:0] fuse_rd_data,
    input wire logic fuse_rd_valid,
    // selects and calibration state
    input wire logic core2_sel_input_b,
    input wire logic core3_sel_input_d,
    input wire logic offset_cal_busy,
    // trim outputs
    input wire logic [OFS_W-1:0] core2_offset,
    input wire logic core2_offset_valid,
    input wire logic [OFS_W-1:0] core3_offset,
    input wire logic [OFS_W-1:0] core4_offset,
    input wire logic [OFS_W-1:0] core5_offset,
    input wire logic [GAIN_W-1:0] core0_gain,
    input wire logic [GAIN_W-1:0] core1_gain,
    input wire logic [GAIN_W-1:0] core2_gain,
    input wire logic core2_gain_valid,
    input wire logic fuse_load_done
);
    // one clock domain, so clock and disable are given once
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_core2_ofs_gate: assert property (
        !core2_sel_input_b |=> core2_offset == '0 && !core2_offset_valid)
        else $error("core2 offset present while first input sampled");
    a_core2_gain_gate: assert property (
        core2_sel_input_b |=> core2_gain == '0 && !core2_gain_valid)
        else $error("core2 gain present while second input sampled");
    a_core4_follow: assert property (
        bus_req.wr && bus_req.addr == aogt_pkg::ADDR_OFFSET_TRIM_CORE4 && fuse_load_done
        && !offset_cal_busy |-> ##2 core4_offset == $past(bus_req.wdata[OFS_W-1:0], 2))
        else $error("core4 offset does not follow its register");
    a_core0_follow: assert property (
        bus_req.wr && bus_req.addr == aogt_pkg::ADDR_FINE_GAIN_CORE0 && fuse_load_done
        |-> ##2 core0_gain == $past(bus_req.wdata[GAIN_W-1:0], 2))
        else $error("core0 gain does not follow its register");
    a_cal_read_zero: assert property (
        bus_req.rd && offset_cal_busy && bus_req.addr inside {[12'h336:12'h33e]}
        |=> bus_rdata == 16'h0000)
        else $error("offset read during calibration not blanked");
    a_fuse_en_pulse: assert property (
        fuse_rd_en |=> !fuse_rd_en)
        else $error("fuse request longer than one cycle");
    a_fuse_idx_hold: assert property (
        !fuse_rd_valid |=> $stable(fuse_rd_index))
        else $error("fuse index moved before its word was taken");
    a_done_after_eight: assert property (
        $rose(fuse_load_done) |-> $past(fuse_rd_valid) && $past(fuse_rd_index) == 3'd7)
        else $error("load done raised before the last fuse word");
endmodule // aogt_trim_regs_checker

bind aogt_trim_regs aogt_trim_regs_checker #(.OFS_W(OFS_W), .GAIN_W(GAIN_W)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .fuse_rd_en(fuse_rd_en), .fuse_rd_index(fuse_rd_index), .fuse_rd_data(fuse_rd_data),
    .fuse_rd_valid(fuse_rd_valid), .core2_sel_input_b(core2_sel_input_b),
    .core3_sel_input_d(core3_sel_input_d), .offset_cal_busy(offset_cal_busy),
    .core2_offset(core2_offset), .core2_offset_valid(core2_offset_valid),
    .core3_offset(core3_offset), .core4_offset(core4_offset), .core5_offset(core5_offset),
    .core0_gain(core0_gain), .core1_gain(core1_gain), .core2_gain(core2_gain),
    .core2_gain_valid(core2_gain_valid), .fuse_load_done(fuse_load_done));
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// self-checking bench for the trim register bank
// ---------------------------------------------------------------------------
module tb_top;
    logic sys_clk = 1'b0;  // 25 MHz
    logic rst_n = 1'b0;  // synchronous, active low
    aogt_pkg::aogt_bus_req_type req = '0;  // register bus request
    logic [15:0] bus_rdata;
    logic fuse_rd_en, fuse_rd_valid = 1'b0, fuse_load_done, c2ov, c2gv;
    logic [2:0] fuse_rd_index;
    logic [15:0] fuse_rd_data = 16'h0000;
    logic sel_b = 1'b0, sel_d = 1'b0, cal_busy = 1'b0;
    logic [11:0] c2o, c3o, c4o, c5o;
    logic [4:0] g0, g1, g2;
    logic [31:0] seed = 32'h0000_003d;  // xorshift state
    logic [15:0] fw [8];  // fuse contents
    logic [11:0] adr [8];  // register map in fuse order
    int mdl [8];  // expected register contents
    int mismatches = 0;
    int n_compared = 0;
    int pend = 0;
    int lat = 0;
    int n_valid = 0;

    always #20 sys_clk = ~sys_clk;

    aogt_trim_regs dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .bus_req(req), .bus_rdata(bus_rdata),
        .fuse_rd_en(fuse_rd_en), .fuse_rd_index(fuse_rd_index), .fuse_rd_data(fuse_rd_data),
        .fuse_rd_valid(fuse_rd_valid), .core2_sel_input_b(sel_b), .core3_sel_input_d(sel_d),
        .offset_cal_busy(cal_busy), .core2_offset(c2o), .core2_offset_valid(c2ov),
        .core3_offset(c3o), .core4_offset(c4o), .core5_offset(c5o), .core0_gain(g0),
        .core1_gain(g1), .core2_gain(g2), .core2_gain_valid(c2gv),
        .fuse_load_done(fuse_load_done));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // ------------------------------------------------------------------------
    // fuse memory: random latency, data line scrambles between answers
    // ------------------------------------------------------------------------
    // the answered word stands only in the cycle of the answer; the line
    // toggles otherwise, so a word taken in the wrong cycle shows up
    always @(posedge sys_clk) begin
        if (rst_n && !fuse_rd_en && pend == 1 && lat == 0) begin
            pend = 0;
            n_valid++;
            fuse_rd_valid <= 1'b1;
            fuse_rd_data <= fw[fuse_rd_index];
        end else begin
            fuse_rd_valid <= 1'b0;
            fuse_rd_data <= ~fuse_rd_data;
            if (!rst_n) begin
                pend = 0;
            end else if (fuse_rd_en) begin
                pend = 1;
                lat = int'(xs() % 4);
            end else if (pend == 1) begin
                lat--;
            end
        end
    end

    // ------------------------------------------------------------------------
    // bus cycle, comparison and verdict
    // ------------------------------------------------------------------------
    task bus(input logic w, input logic r, input logic [11:0] a, input logic [15:0] d,
             output logic [15:0] q);
        req <= '{addr: a, wdata: d, wr: w, rd: r};
        @(posedge sys_clk);
        #1 q = bus_rdata;  // read data stand in this cycle only
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask

    task rd_all();
        logic [15:0] q;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 1'b1, adr[i], 16'h0000, q);
            chk(q, 16'(mdl[i]));
        end
    endtask

    // two idle cycles let the selects reach the trim outputs
    task cores(input logic sb, input logic sd);
        logic [15:0] q;
        sel_b <= sb;
        sel_d <= sd;
        bus(1'b0, 1'b0, 12'h000, 16'h0000, q);
        bus(1'b0, 1'b0, 12'h000, 16'h0000, q);
        chk(16'(c2o), 16'(sb ? mdl[0] : 0));
        chk(16'(c2ov), 16'(sb));
        chk(16'(c3o), 16'(sd ? mdl[2] : mdl[1]));
        chk(16'(c4o), 16'(mdl[3]));
        chk(16'(c5o), 16'(mdl[4]));
        chk(16'(g0), 16'(mdl[5]));
        chk(16'(g1), 16'(mdl[6]));
        chk(16'(g2), 16'(sb ? 0 : mdl[7]));
        chk(16'(c2gv), 16'(!sb));
    endtask

    task results();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // watchdog: the tests need well under 2000 cycles
    initial begin
        #200000;
        mismatches++;
        results();
    end

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        logic [15:0] q;
        logic [15:0] d;
        int i;
        int nv0;
        adr = '{aogt_pkg::ADDR_OFFSET_TRIM_CORE2_INPUT_B, aogt_pkg::ADDR_OFFSET_TRIM_CORE3_INPUT_C,
                aogt_pkg::ADDR_OFFSET_TRIM_CORE3_INPUT_D, aogt_pkg::ADDR_OFFSET_TRIM_CORE4,
                aogt_pkg::ADDR_OFFSET_TRIM_CORE5, aogt_pkg::ADDR_FINE_GAIN_CORE0,
                aogt_pkg::ADDR_FINE_GAIN_CORE1, aogt_pkg::ADDR_FINE_GAIN_CORE2_INPUT_A};
        for (int k = 0; k < 8; k++) fw[k] = 16'(xs());
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        // fuse load after reset
        for (int k = 0; k < 400 && fuse_load_done !== 1'b1; k++) @(posedge sys_clk);
        #1;
        chk(16'(fuse_load_done), 16'h0001);
        for (int k = 0; k < 8; k++) mdl[k] = fw[k] & (k < 5 ? 'hfff : 'h1f);
        rd_all();
        cores(1'b0, 1'b0);
        cores(1'b1, 1'b1);
        $display("test fuse load done");
        // random writes, reserved bits random, each read back at once
        repeat (24) begin
            i = int'(xs() % 8);
            d = 16'(xs());
            mdl[i] = d & (i < 5 ? 'hfff : 'h1f);
            bus(1'b1, 1'b0, adr[i], d, q);
            bus(1'b0, 1'b1, adr[i], 16'h0000, q);
            chk(q, 16'(mdl[i]));
            cores(1'(xs()), 1'(xs()));
        end
        bus(1'b1, 1'b0, 12'h340, 16'hffff, q);
        bus(1'b0, 1'b1, 12'h340, 16'h0000, q);
        chk(q, 16'h0000);
        $display("test random access done");
        // calibration running: offsets blanked, gains still reachable
        cal_busy <= 1'b1;
        bus(1'b1, 1'b0, adr[3], 16'h0abc, q);
        bus(1'b0, 1'b1, adr[3], 16'h0000, q);
        chk(q, 16'h0000);
        bus(1'b0, 1'b1, aogt_pkg::ADDR_TRIM_STATUS, 16'h0000, q);
        chk(q, 16'h0005);
        bus(1'b0, 1'b1, adr[5], 16'h0000, q);
        chk(q, 16'(mdl[5]));
        cal_busy <= 1'b0;
        rd_all();
        $display("test calibration guard done");
        // reload from fuses overwrites software values
        nv0 = n_valid;
        bus(1'b1, 1'b0, aogt_pkg::ADDR_TRIM_CONTROL, 16'h0001, q);
        bus(1'b0, 1'b1, aogt_pkg::ADDR_TRIM_STATUS, 16'h0000, q);
        chk(q, 16'h0002);
        for (int k = 0; k < 400 && n_valid < nv0 + 8; k++) bus(1'b0, 1'b0, 12'h000, 16'h0000, q);
        repeat (3) bus(1'b0, 1'b0, 12'h000, 16'h0000, q);
        for (int k = 0; k < 8; k++) mdl[k] = fw[k] & (k < 5 ? 'hfff : 'h1f);
        rd_all();
        cores(1'b1, 1'b0);
        $display("test fuse reload done");
        results();
    end
endmodule // tb_top
`default_nettype wire
